// ---- hif_pkg.sv ----
// Shared offsets, field layouts, reset values and types of the host register bank.
`default_nettype none
package hif_pkg;

	// Register byte offsets on the host bus
	localparam logic [7:0]  OFS_RX_DATA      = 8'h00;
	localparam logic [7:0]  OFS_INT_EN       = 8'h5c;
	localparam logic [7:0]  OFS_BYTE_TEST    = 8'h64;
	localparam logic [7:0]  OFS_FIFO_LVL     = 8'h68;
	localparam logic [7:0]  OFS_RX_CFG       = 8'h6c;

	// Interrupt enable mask: writable positions and reset
	localparam logic [31:0] INT_EN_WMASK     = 32'h83bf_e7df;
	localparam logic [31:0] INT_EN_RESET     = 32'h0000_0000;

	// Byte-order test word
	localparam logic [31:0] BYTE_TEST_VALUE  = 32'h8765_4321;

	// FIFO level thresholds
	localparam int          TXA_LSB          = 24;
	localparam int          TSL_LSB          = 16;
	localparam int          RSL_LSB          = 0;
	localparam logic [31:0] FIFO_LVL_WMASK   = 32'hffff_00ff;
	localparam logic [31:0] FIFO_LVL_RESET   = 32'h4800_0000;
	localparam int          TX_BLOCK_SHIFT   = 6;
	localparam int          WORD_SHIFT       = 0;

	// Receive configuration fields
	localparam int          ALIGN_LSB        = 30;
	localparam int          CNT_LSB          = 16;
	localparam int          DISCARD_BIT      = 15;
	localparam int          OFF_LSB          = 8;
	localparam int          CNT_W            = 12;
	localparam int          OFF_W            = 5;
	localparam logic [11:0] CNT_RESET        = 12'h000;
	localparam logic [4:0]  OFF_RESET        = 5'h00;

	localparam logic [31:0] FILLER_WORD      = 32'h0000_0000;

	typedef enum logic [1:0] {
		ALIGN_4    = 2'b00,
		ALIGN_16   = 2'b01,
		ALIGN_32   = 2'b10,
		ALIGN_RSVD = 2'b11
	} hif_align_e;

	typedef struct packed {
		hif_align_e  align;
		logic [11:0] dma_cnt;
		logic [4:0]  offset;
	} hif_rx_cfg_s;

	typedef struct packed {
		logic        valid;
		logic        last;
		logic [31:0] data;
	} hif_rxd_s;

	// Words per aligned buffer end, minus one; reserved code behaves as 4-byte
	function automatic logic [2:0] align_mask(input hif_align_e a);
		logic [2:0] m;
		m = 3'h0;
		unique case (a)
			ALIGN_4:    m = 3'h0;
			ALIGN_16:   m = 3'h3;
			ALIGN_32:   m = 3'h7;
			ALIGN_RSVD: m = 3'h0;
		endcase
		return m;
	endfunction

endpackage
`default_nettype wire

// ---- hif_lvl_cmp.sv ----
// Registered compare of a FIFO level against a scaled threshold.
`timescale 1ns/1ps
`default_nettype none
module hif_lvl_cmp #(
	parameter int LVL_W = 16,
	parameter int THR_W = 8,
	parameter int SHIFT = 0
) (
	input  wire logic             mclk_i,
	input  wire logic             sys_rst_i,
	input  wire logic [LVL_W-1:0] level_i,
	input  wire logic [THR_W-1:0] thresh_i,
	output logic                  above_o
);

	logic [LVL_W+SHIFT+THR_W-1:0] thr_scaled;
	logic [LVL_W+SHIFT+THR_W-1:0] lvl_wide;

	// Shift instead of a trailing zero field, which would be empty when SHIFT is 0
	assign thr_scaled = {{(LVL_W+SHIFT){1'b0}}, thresh_i} << SHIFT;
	assign lvl_wide   = {{(SHIFT+THR_W){1'b0}}, level_i};

	// Strictly greater: equal to the threshold does not raise the event
	always_ff @(posedge mclk_i) begin
		if (sys_rst_i) begin
			above_o <= 1'b0;
		end else begin
			above_o <= (lvl_wide > thr_scaled);
		end
	end

endmodule // hif_lvl_cmp
`default_nettype wire

// ---- hif_rx_pad.sv ----
// Receive buffer read sequencer: leading offset words, data, trailing filler words.
`timescale 1ns/1ps
`default_nettype none
module hif_rx_pad (
	input  wire logic              mclk_i,
	input  wire logic              sys_rst_i,
	input  wire logic              flush_i,
	input  wire logic              rd_i,
	input  wire hif_pkg::hif_align_e align_i,
	input  wire logic [2:0]        word_off_i,
	input  wire hif_pkg::hif_rxd_s rxd_i,
	output logic [31:0]            word_o,
	output logic                   pop_o
);

	typedef enum logic [1:0] {
		ST_HEAD = 2'b00,
		ST_DATA = 2'b01,
		ST_PAD  = 2'b10
	} hif_pad_e;

	hif_pad_e   st_q;
	logic [2:0] lead_q;
	logic [2:0] wcnt_q;
	logic [2:0] pad_q;
	logic       lead_now;
	logic [2:0] rem;
	logic [2:0] mask;

	// Offset word count is read live, so a change applies at the next word read
	assign lead_now = (st_q == ST_HEAD) && (lead_q < word_off_i);
	assign mask     = hif_pkg::align_mask(align_i);
	assign rem      = 3'(wcnt_q + 3'h1) & mask;
	assign pop_o    = rd_i && rxd_i.valid && !lead_now && (st_q != ST_PAD);
	assign word_o   = pop_o ? rxd_i.data : hif_pkg::FILLER_WORD;

	always_ff @(posedge mclk_i) begin
		if (sys_rst_i || flush_i) begin
			st_q   <= ST_HEAD;
			lead_q <= 3'h0;
			wcnt_q <= 3'h0;
			pad_q  <= 3'h0;
		end else if (rd_i) begin
			unique case (st_q)
				ST_HEAD: begin
					if (lead_now) begin
						lead_q <= 3'(lead_q + 3'h1);
						wcnt_q <= 3'(wcnt_q + 3'h1);
					end else if (pop_o) begin
						wcnt_q <= 3'(wcnt_q + 3'h1);
						st_q   <= ST_DATA;
					end
				end
				ST_DATA: begin
					if (pop_o) begin
						wcnt_q <= 3'(wcnt_q + 3'h1);
					end
				end
				ST_PAD: begin
					pad_q <= 3'(pad_q - 3'h1);
					if (pad_q == 3'h1) begin
						st_q   <= ST_HEAD;
						lead_q <= 3'h0;
						wcnt_q <= 3'h0;
					end
				end
			endcase
			// Last data word: work out filler up to the selected end alignment
			if (pop_o && rxd_i.last) begin
				if (rem == 3'h0) begin
					st_q   <= ST_HEAD;
					lead_q <= 3'h0;
					wcnt_q <= 3'h0;
				end else begin
					st_q  <= ST_PAD;
					pad_q <= 3'(mask - rem + 3'h1);
				end
			end
		end
	end

endmodule // hif_rx_pad
`default_nettype wire

// ---- hif_regs.sv ----
// Host register bank: interrupt mask, byte test, FIFO thresholds, receive configuration.
`timescale 1ns/1ps
`default_nettype none
module hif_regs #(
	parameter int LVL_W = 16
) (
	input  wire logic             mclk_i,
	input  wire logic             sys_rst_i,
	// Host register access, synchronous one-cycle strobes
	input  wire logic             host_wr_i,
	input  wire logic             host_rd_i,
	input  wire logic [7:0]       host_addr_i,
	input  wire logic [31:0]      host_wdata_i,
	output logic [31:0]           host_rdata_o,
	output logic                  host_rvalid_o,
	// Interrupt status sources and line
	input  wire logic [31:0]      interrupt_status_flags_i,
	output logic                  host_irq_o,
	// FIFO levels
	input  wire logic [LVL_W-1:0] tx_data_free_bytes_i,
	input  wire logic [LVL_W-1:0] tx_status_used_i,
	input  wire logic [LVL_W-1:0] rx_status_used_i,
	output logic                  transmit_space_available_event_o,
	output logic                  transmit_status_level_event_o,
	output logic                  receive_status_level_event_o,
	// Receive data FIFO head and control
	input  wire logic             rxd_valid_i,
	input  wire logic             rxd_last_i,
	input  wire logic [31:0]      rxd_data_i,
	output logic                  rxd_pop_o,
	output logic                  rx_flush_o,
	output logic                  rx_dma_done_o,
	output logic [1:0]            receive_byte_shift_o
);

	logic [31:0]          int_en_q;
	logic [31:0]          fifo_lvl_q;
	hif_pkg::hif_align_e  align_q;
	logic [4:0]           offset_q;
	logic [11:0]          dma_cnt_q;
	hif_pkg::hif_rx_cfg_s rx_cfg;
	hif_pkg::hif_rxd_s    rxd;

	logic                 wr_int_en;
	logic                 wr_fifo_lvl;
	logic                 wr_rx_cfg;
	logic                 rd_data_port;
	logic [31:0]          pad_word;
	logic                 pad_pop;
	logic [31:0]          rdata_d;
	logic [31:0]          rx_cfg_view;
	logic                 cnt_write;
	logic [11:0]          cnt_new;

	// Strobe qualified by one register offset
	function automatic logic reg_hit(
		input logic       strobe,
		input logic [7:0] addr,
		input logic [7:0] ofs
	);
		return strobe && (addr == ofs);
	endfunction

	assign wr_int_en    = reg_hit(host_wr_i, host_addr_i, hif_pkg::OFS_INT_EN);
	assign wr_fifo_lvl  = reg_hit(host_wr_i, host_addr_i, hif_pkg::OFS_FIFO_LVL);
	assign wr_rx_cfg    = reg_hit(host_wr_i, host_addr_i, hif_pkg::OFS_RX_CFG);
	assign rd_data_port = reg_hit(host_rd_i, host_addr_i, hif_pkg::OFS_RX_DATA);

	assign rxd.valid = rxd_valid_i;
	assign rxd.last  = rxd_last_i;
	assign rxd.data  = rxd_data_i;

	// Interrupt enable mask
	always_ff @(posedge mclk_i) begin
		if (sys_rst_i) begin
			int_en_q <= hif_pkg::INT_EN_RESET;
		end else if (wr_int_en) begin
			// Reserved positions are cut by the mask and stay zero
			int_en_q <= host_wdata_i & hif_pkg::INT_EN_WMASK;
		end
	end

	// Status arrives untouched from outside; only the line is gated
	always_ff @(posedge mclk_i) begin
		if (sys_rst_i) begin
			host_irq_o <= 1'b0;
		end else begin
			host_irq_o <= |(interrupt_status_flags_i & int_en_q);
		end
	end

	// FIFO level thresholds
	always_ff @(posedge mclk_i) begin
		if (sys_rst_i) begin
			fifo_lvl_q <= hif_pkg::FIFO_LVL_RESET;
		end else if (wr_fifo_lvl) begin
			fifo_lvl_q <= host_wdata_i & hif_pkg::FIFO_LVL_WMASK;
		end
	end

	hif_lvl_cmp #(
		.LVL_W (LVL_W),
		.THR_W (8),
		.SHIFT (hif_pkg::TX_BLOCK_SHIFT)
	) u_txa_cmp (
		.mclk_i    (mclk_i),
		.sys_rst_i (sys_rst_i),
		.level_i   (tx_data_free_bytes_i),
		.thresh_i  (fifo_lvl_q[hif_pkg::TXA_LSB +: 8]),
		.above_o   (transmit_space_available_event_o)
	);

	hif_lvl_cmp #(
		.LVL_W (LVL_W),
		.THR_W (8),
		.SHIFT (hif_pkg::WORD_SHIFT)
	) u_tsl_cmp (
		.mclk_i    (mclk_i),
		.sys_rst_i (sys_rst_i),
		.level_i   (tx_status_used_i),
		.thresh_i  (fifo_lvl_q[hif_pkg::TSL_LSB +: 8]),
		.above_o   (transmit_status_level_event_o)
	);

	hif_lvl_cmp #(
		.LVL_W (LVL_W),
		.THR_W (8),
		.SHIFT (hif_pkg::WORD_SHIFT)
	) u_rsl_cmp (
		.mclk_i    (mclk_i),
		.sys_rst_i (sys_rst_i),
		.level_i   (rx_status_used_i),
		.thresh_i  (fifo_lvl_q[hif_pkg::RSL_LSB +: 8]),
		.above_o   (receive_status_level_event_o)
	);

	// Receive configuration: alignment and offset fields, each in its own register
	always_ff @(posedge mclk_i) begin
		if (sys_rst_i) begin
			align_q  <= hif_pkg::ALIGN_4;
			offset_q <= hif_pkg::OFF_RESET;
		end else if (wr_rx_cfg) begin
			align_q  <= hif_pkg::hif_align_e'(host_wdata_i[hif_pkg::ALIGN_LSB +: 2]);
			offset_q <= host_wdata_i[hif_pkg::OFF_LSB +: hif_pkg::OFF_W];
		end
	end

	assign cnt_write = wr_rx_cfg;
	assign cnt_new   = host_wdata_i[hif_pkg::CNT_LSB +: hif_pkg::CNT_W];

	// Countdown: a host write wins over a same-cycle decrement
	always_ff @(posedge mclk_i) begin
		if (sys_rst_i) begin
			dma_cnt_q     <= hif_pkg::CNT_RESET;
			rx_dma_done_o <= 1'b0;
		end else begin
			rx_dma_done_o <= 1'b0;
			if (cnt_write) begin
				dma_cnt_q <= cnt_new;
			end else if (rd_data_port && (dma_cnt_q != 12'h000)) begin
				dma_cnt_q <= 12'(dma_cnt_q - 12'h001);
				if (dma_cnt_q == 12'h001) begin
					rx_dma_done_o <= 1'b1;
				end
			end
		end
	end

	// Fields are stored apart so that each has a single writing process
	assign rx_cfg = {align_q, dma_cnt_q, offset_q};

	// Discard is a one-cycle flush pulse; the bit itself is never stored
	always_ff @(posedge mclk_i) begin
		if (sys_rst_i) begin
			rx_flush_o <= 1'b0;
		end else begin
			rx_flush_o <= wr_rx_cfg && host_wdata_i[hif_pkg::DISCARD_BIT];
		end
	end

	// Byte part of the offset goes to the data packer; the word part is inserted here
	always_ff @(posedge mclk_i) begin
		if (sys_rst_i) begin
			receive_byte_shift_o <= 2'b00;
		end else begin
			receive_byte_shift_o <= rx_cfg.offset[1:0];
		end
	end

	hif_rx_pad u_rx_pad (
		.mclk_i     (mclk_i),
		.sys_rst_i  (sys_rst_i),
		.flush_i    (rx_flush_o),
		.rd_i       (rd_data_port),
		.align_i    (rx_cfg.align),
		.word_off_i (rx_cfg.offset[4:2]),
		.rxd_i      (rxd),
		.word_o     (pad_word),
		.pop_o      (pad_pop)
	);

	// Pop is registered, so the head advances one cycle after the read
	always_ff @(posedge mclk_i) begin
		if (sys_rst_i) begin
			rxd_pop_o <= 1'b0;
		end else begin
			rxd_pop_o <= pad_pop;
		end
	end

	always_comb begin
		rx_cfg_view = 32'h0000_0000;
		rx_cfg_view[hif_pkg::ALIGN_LSB +: 2]           = rx_cfg.align;
		rx_cfg_view[hif_pkg::CNT_LSB +: hif_pkg::CNT_W] = rx_cfg.dma_cnt;
		rx_cfg_view[hif_pkg::OFF_LSB +: hif_pkg::OFF_W] = rx_cfg.offset;
	end

	// Read mux; unmapped offsets read zero
	always_comb begin
		rdata_d = 32'h0000_0000;
		unique case (host_addr_i)
			hif_pkg::OFS_RX_DATA:   rdata_d = pad_word;
			hif_pkg::OFS_INT_EN:    rdata_d = int_en_q;
			hif_pkg::OFS_BYTE_TEST: rdata_d = hif_pkg::BYTE_TEST_VALUE;
			hif_pkg::OFS_FIFO_LVL:  rdata_d = fifo_lvl_q;
			hif_pkg::OFS_RX_CFG:    rdata_d = rx_cfg_view;
			default:                rdata_d = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge mclk_i) begin
		if (sys_rst_i) begin
			host_rdata_o  <= 32'h0000_0000;
			host_rvalid_o <= 1'b0;
		end else begin
			host_rvalid_o <= host_rd_i;
			if (host_rd_i) begin
				host_rdata_o <= rdata_d;
			end
		end
	end

endmodule // hif_regs
`default_nettype wire

// ---- hif_regs_asserts.sv ----
// Port-level checker for the host register bank.
`timescale 1ns/1ps
`default_nettype none
module hif_regs_asserts #(
	parameter int LVL_W = 16
) (
	input wire logic             mclk_i,
	input wire logic             sys_rst_i,
	input wire logic             host_wr_i,
	input wire logic             host_rd_i,
	input wire logic [7:0]       host_addr_i,
	input wire logic [31:0]      host_wdata_i,
	input wire logic [31:0]      host_rdata_o,
	input wire logic             host_rvalid_o,
	input wire logic [31:0]      interrupt_status_flags_i,
	input wire logic             host_irq_o,
	input wire logic [LVL_W-1:0] tx_data_free_bytes_i,
	input wire logic             transmit_space_available_event_o,
	input wire logic             rx_flush_o,
	input wire logic             rx_dma_done_o
);
	logic [31:0] m_q;
	logic [7:0]  t_q;
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (sys_rst_i);
	// Shadows rebuilt from bus writes, so gating is judged from the pins alone
	always_ff @(posedge mclk_i) begin
		if (sys_rst_i) begin
			m_q <= 32'h0000_0000;
			t_q <= 8'h48;
		end else if (host_wr_i && host_addr_i == 8'h5c) begin
			m_q <= host_wdata_i & 32'h83bf_e7df;
		end else if (host_wr_i && host_addr_i == 8'h68) begin
			t_q <= host_wdata_i[31:24];
		end
	end
	AST_IRQ_GATE:
		assert property (host_irq_o == |($past(interrupt_status_flags_i) & $past(m_q)))
		else $error("irq gating");
	AST_RVALID:
		assert property (host_rvalid_o == $past(host_rd_i)) else $error("rvalid timing");
	AST_BYTE_TEST:
		assert property (host_rd_i && host_addr_i == 8'h64 |=> host_rdata_o == 32'h8765_4321)
		else $error("byte test word");
	AST_MASK_READ:
		assert property (host_rd_i && host_addr_i == 8'h5c |=> host_rdata_o == $past(m_q))
		else $error("mask readback");
	AST_TX_SPACE:
		assert property (transmit_space_available_event_o ==
			($past(tx_data_free_bytes_i) > {$past(t_q), 6'h00})) else $error("tx space event");
	AST_FLUSH_PULSE:
		assert property (rx_flush_o ==
			$past(host_wr_i && host_addr_i == 8'h6c && host_wdata_i[15])) else $error("flush");
	AST_DISCARD_RD:
		assert property (host_rd_i && host_addr_i == 8'h6c |=> !host_rdata_o[15])
		else $error("discard bit stuck");
	AST_DONE_CAUSE:
		assert property (rx_dma_done_o |-> $past(host_rd_i && host_addr_i == 8'h00))
		else $error("done without read");
	AST_DONE_SINGLE:
		assert property (rx_dma_done_o |=> !rx_dma_done_o) else $error("done too long");
	cover property (host_irq_o);
	cover property (transmit_space_available_event_o);
	cover property (rx_dma_done_o);
	cover property (rx_flush_o);
endmodule // hif_regs_asserts
bind hif_regs hif_regs_asserts #(.LVL_W(LVL_W)) chk_u (.mclk_i, .sys_rst_i, .host_wr_i,
	.host_rd_i, .host_addr_i, .host_wdata_i, .host_rdata_o, .host_rvalid_o,
	.interrupt_status_flags_i, .host_irq_o, .tx_data_free_bytes_i,
	.transmit_space_available_event_o, .rx_flush_o, .rx_dma_done_o);
`default_nettype wire

// ---- hif_rxq_model.sv ----
// Receive data FIFO head model feeding the register bank.
`timescale 1ns/1ps
`default_nettype none
module hif_rxq_model (
	input  wire logic        mclk_i,
	input  wire logic        sys_rst_i,
	input  wire logic        load_i,
	input  wire logic [3:0]  len_i,
	input  wire logic        pop_i,
	input  wire logic        flush_i,
	output hif_pkg::hif_rxd_s head_o
);
	logic [3:0] left_q;
	logic [3:0] idx_q;
	always_ff @(posedge mclk_i) begin
		if (sys_rst_i || flush_i) begin
			left_q <= 4'h0;
			idx_q <= 4'h0;
		end else if (load_i) begin
			left_q <= len_i;
			idx_q <= 4'h0;
		end else if (pop_i && left_q != 4'h0) begin
			left_q <= left_q - 4'h1;
			idx_q <= idx_q + 4'h1;
		end
	end
	// An empty head shows inverted data so a stale word never passes for a real one
	always_comb begin
		head_o.valid = (left_q != 4'h0);
		head_o.last = (left_q == 4'h1);
		head_o.data = (left_q != 4'h0) ? {28'hd0d0000, idx_q} : ~{28'hd0d0000, idx_q};
	end
endmodule // hif_rxq_model
`default_nettype wire

// ---- test_host_irq_mask_fifo_level_rx_config.sv ----
// Self-checking testbench for the host register bank.
`timescale 1ns/1ps
`default_nettype none
module test_host_irq_mask_fifo_level_rx_config;
	logic              mclk_i, sys_rst_i, wr, rd, rvalid, irq, pop, flush, done, load;
	logic [7:0]        addr;
	logic [31:0]       wdata, rdata, flags;
	logic [15:0]       free, tu, ru;
	logic [2:0]        ev;
	logic [3:0]        len;
	logic [1:0]        bshift;
	hif_pkg::hif_rxd_s head;
	int                fail_count = 0, tests_run = 0, done_cnt = 0, d0;
	hif_regs #(.LVL_W(16)) dut_u (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .host_wr_i(wr),
		.host_rd_i(rd), .host_addr_i(addr), .host_wdata_i(wdata), .host_rdata_o(rdata),
		.host_rvalid_o(rvalid), .interrupt_status_flags_i(flags), .host_irq_o(irq),
		.tx_data_free_bytes_i(free), .tx_status_used_i(tu), .rx_status_used_i(ru),
		.transmit_space_available_event_o(ev[2]), .transmit_status_level_event_o(ev[1]),
		.receive_status_level_event_o(ev[0]), .rxd_valid_i(head.valid), .rxd_last_i(head.last),
		.rxd_data_i(head.data), .rxd_pop_o(pop), .rx_flush_o(flush), .rx_dma_done_o(done),
		.receive_byte_shift_o(bshift));
	hif_rxq_model fifo_u (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .load_i(load), .len_i(len),
		.pop_i(pop), .flush_i(flush), .head_o(head));
	always #5 mclk_i = ~mclk_i;
	always @(posedge mclk_i) if (done === 1'b1) done_cnt++;
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			fail_count++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wrr(input logic [7:0] a, input logic [31:0] d);
		@(negedge mclk_i);
		wr = 1'b1;
		addr = a;
		wdata = d;
		@(negedge mclk_i);
		wr = 1'b0;
	endtask
	// Idle cycle after each read keeps data-port reads three cycles apart
	task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
		@(negedge mclk_i);
		rd = 1'b1;
		addr = a;
		@(negedge mclk_i);
		rd = 1'b0;
		chk({31'h0, rvalid}, 32'h1);
		chk(rdata, exp);
		@(negedge mclk_i);
	endtask
	task automatic irqc(input logic [31:0] m, input logic [31:0] s, input logic e);
		wrr(8'h5c, m);
		flags = s;
		repeat (2) @(negedge mclk_i);
		chk({31'h0, irq}, {31'h0, e});
	endtask
	task automatic lvl(input logic [15:0] f, t, r, input logic [2:0] e);
		free = f;
		tu = t;
		ru = r;
		repeat (2) @(negedge mclk_i);
		chk({29'h0, ev}, {29'h0, e});
	endtask
	task automatic ld(input logic [3:0] n);
		load = 1'b1;
		len = n;
		@(negedge mclk_i);
		load = 1'b0;
	endtask
	task automatic rxpkt(input logic [31:0] cfg, input int lead, input int total);
		int          s;
		logic [31:0] e;
		s = done_cnt;
		// Alignment is set before the packet; low offset bits are left at zero
		wrr(8'h6c, cfg | (32'(total) << 16));
		ld(4'h3);
		for (int i = 0; i < total; i++) begin
			e = (i < lead || i >= lead + 3) ? 32'h0 : 32'hd0d0_0000 + i - lead;
			rdc(8'h00, e);
		end
		chk(done_cnt - s, 32'h1);
		rdc(8'h00, 32'h0);
	endtask
	task automatic results;
		$display("checks %0d mismatches %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	initial begin
		#100_000;
		fail_count++;
		results();
	end
	initial begin
		mclk_i = 1'b0;
		sys_rst_i = 1'b1;
		{wr, rd, load, addr, wdata, flags, free, tu, ru, len} = '0;
		repeat (4) @(negedge mclk_i);
		sys_rst_i = 1'b0;
		rdc(8'h5c, 32'h0);
		rdc(8'h64, 32'h8765_4321);
		rdc(8'h68, 32'h4800_0000);
		rdc(8'h6c, 32'h0);
		lvl(16'h1200, 16'h0, 16'h0, 3'b000);
		lvl(16'h1201, 16'h1, 16'h1, 3'b111);
		wrr(8'h5c, 32'hffff_ffff);
		rdc(8'h5c, 32'h83bf_e7df);
		wrr(8'h64, 32'h0);
		rdc(8'h64, 32'h8765_4321);
		rdc(8'h7c, 32'h0);
		irqc(32'hffff_ffff, 32'h0000_0020, 1'b0);
		irqc(32'hffff_ffff, 32'h8000_0000, 1'b1);
		irqc(32'h0000_0200, 32'h0000_0100, 1'b0);
		irqc(32'h0000_0200, 32'h0000_0200, 1'b1);
		irqc(32'h0000_0000, 32'hffff_ffff, 1'b0);
		flags = 32'h0;
		wrr(8'h68, 32'h0203_ff04);
		rdc(8'h68, 32'h0203_0004);
		lvl(16'h0080, 16'h0003, 16'h0004, 3'b000);
		lvl(16'h0081, 16'h0004, 16'h0005, 3'b111);
		rxpkt(32'h0000_0000, 0, 3);
		rxpkt(32'h4000_0000, 0, 4);
		rxpkt(32'h8000_0000, 0, 8);
		rxpkt(32'hc000_0000, 0, 3);
		rxpkt(32'h4000_0800, 2, 8);
		wrr(8'h6c, 32'h0000_8000);
		rdc(8'h6c, 32'h0);
		// Receive side is purged, so the byte part of the offset may change now
		wrr(8'h6c, 32'h0000_0300);
		rdc(8'h6c, 32'h0000_0300);
		chk({30'h0, bshift}, 32'h3);
		d0 = done_cnt;
		wrr(8'h6c, 32'h0003_0000);
		ld(4'h3);
		rdc(8'h00, 32'hd0d0_0000);
		wrr(8'h6c, 32'h0001_0000);
		rdc(8'h00, 32'hd0d0_0001);
		chk(done_cnt - d0, 32'h1);
		rdc(8'h00, 32'hd0d0_0002);
		chk(done_cnt - d0, 32'h1);
		ld(4'h3);
		rdc(8'h00, 32'hd0d0_0000);
		wrr(8'h6c, 32'h0000_8000);
		rdc(8'h00, 32'h0);
		results();
	end
endmodule // test_host_irq_mask_fifo_level_rx_config
`default_nettype wire
